// ===== design/cbc_codec.v
/*
 * character buffer event word codec: receive processor pushes 16-bit event
 * words through a fifo into the character buffer; the display side reads a
 * position and gets the decoded character, side, enhancements or symbol.
 * assumes one 100 MHz clock, classic wishbone for control, and a writer
 * that composes only legal words.
 */
// Function
// [RULE_01] one 16-bit word per position, 64-Kbyte buffer
// [RULE_02] character code in bits 7..0, any value
// [RULE_03] mask 0100 equal 0100 means data word
// [RULE_04] side bit 0400: clear transmit, set receive
// [RULE_05] underline and receive side share one bit
// [RULE_06] decode six combinable data enhancement bits
// [RULE_07] 0200 under mask 8300 is special; 8200 reserved
// [RULE_08] event field selects one of seven symbols
// [RULE_09] special words show symbol, low byte ignored
// [RULE_10] attributes only in high byte, no colour
// [RULE_11] reserved patterns flagged invalid, not rendered
// [RULE_12] writer composes words without reserved combinations
`timescale 1ns/1ns
`include "cbc_consts.vh"
module cbc_codec #(
    parameter DEPTH = 32,
    parameter FAW = 5,
    parameter BUF_AW = 15
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ev_valid,
    output wire o_ev_ready,
    input wire [15:0] i_ev_word,
    input wire i_rd_req,
    input wire [BUF_AW-1:0] i_rd_addr,
    output reg o_rd_valid,
    output reg [1:0] o_rd_class,
    output reg [7:0] o_rd_char,
    output reg o_rd_line_side_select,
    output reg o_rd_underline,
    output reg o_rd_alt_set,
    output reg o_rd_reverse,
    output reg o_rd_hex,
    output reg o_rd_low,
    output reg o_rd_blink,
    output reg o_rd_strike,
    output reg [2:0] o_rd_symbol,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [3:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack
);
    localparam DEPTH_WORDS = `CBC_BUF_BYTES / `CBC_WORD_BYTES;

    // one word per displayed position
    reg [15:0] buf_mem [0:DEPTH_WORDS-1]; // RULE_01
    reg [BUF_AW-1:0] wptr_q;
    reg [BUF_AW:0] count_q;
    reg [15:0] rword_q;
    reg rpend_q;
    wire f_valid;
    wire [15:0] f_data;
    wire f_full;
    wire f_empty;
    wire drain;
    wire clr;
    wire wb_hit;

    assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign clr = wb_hit && i_wb_we && (i_wb_adr == `CBC_REG_CTRL)
        && i_wb_sel[`CBC_CTRL_CLR_BIT / 8] && i_wb_dat[`CBC_CTRL_CLR_BIT];
    // buffer accepts one word per cycle; the fifo absorbs bursts while clear stalls it
    assign drain = f_valid && !clr;

    cbc_fifo #(
        .WIDTH(16),
        .DEPTH(DEPTH),
        .AW(FAW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_ev_valid),
        .o_in_ready(o_ev_ready),
        .i_in_data(i_ev_word), // RULE_12
        .o_out_valid(f_valid),
        .i_out_ready(!clr),
        .o_out_data(f_data),
        .o_full(f_full),
        .o_empty(f_empty)
    );

    always @(posedge i_clk) begin
        if (drain) begin
            buf_mem[wptr_q] <= f_data; // RULE_01
        end
        rword_q <= buf_mem[i_rd_addr];
    end

    // classification of the stored word
    wire is_rsv = ((rword_q & `CBC_RSV_A_MASK) == `CBC_RSV_A_VAL)
        || ((rword_q & `CBC_RSV_B_MASK) == `CBC_RSV_B_VAL);
    wire is_data = ((rword_q & `CBC_CLASS_DATA_MASK) == `CBC_CLASS_DATA_VAL); // RULE_03
    wire is_spec = ((rword_q & `CBC_CLASS_SPEC_MASK) == `CBC_CLASS_SPEC_VAL); // RULE_07
    wire [2:0] evt = rword_q[`CBC_EVT_MSB:`CBC_EVT_LSB];
    wire spec_ok = is_spec && (evt != `CBC_EVT_NONE);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rpend_q <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_class <= `CBC_CLS_INVALID;
            o_rd_char <= 8'h00;
            o_rd_line_side_select <= 1'b0;
            o_rd_underline <= 1'b0;
            o_rd_alt_set <= 1'b0;
            o_rd_reverse <= 1'b0;
            o_rd_hex <= 1'b0;
            o_rd_low <= 1'b0;
            o_rd_blink <= 1'b0;
            o_rd_strike <= 1'b0;
            o_rd_symbol <= 3'h0;
        end else begin
            rpend_q <= i_rd_req;
            o_rd_valid <= rpend_q;
            if (rpend_q) begin
                o_rd_char <= 8'h00;
                o_rd_symbol <= 3'h0;
                o_rd_alt_set <= 1'b0;
                o_rd_reverse <= 1'b0;
                o_rd_hex <= 1'b0;
                o_rd_low <= 1'b0;
                o_rd_blink <= 1'b0;
                o_rd_strike <= 1'b0;
                // receive side is underlined, same bit in both classes
                o_rd_line_side_select <= rword_q[`CBC_SIDE_BIT]; // RULE_04
                o_rd_underline <= rword_q[`CBC_SIDE_BIT]; // RULE_05
                if (is_data && !is_rsv) begin
                    o_rd_class <= `CBC_CLS_DATA;
                    o_rd_char <= rword_q[`CBC_CHAR_MSB:`CBC_CHAR_LSB]; // RULE_02
                    // colour is left to a later map of reverse, blink and low
                    o_rd_alt_set <= rword_q[`CBC_ALT_BIT]; // RULE_06
                    o_rd_reverse <= rword_q[`CBC_REV_BIT]; // RULE_10
                    o_rd_hex <= rword_q[`CBC_HEX_BIT];
                    o_rd_low <= rword_q[`CBC_LOW_BIT];
                    o_rd_blink <= rword_q[`CBC_BLINK_BIT];
                    o_rd_strike <= rword_q[`CBC_STRIKE_BIT];
                end else if (spec_ok && !is_rsv) begin
                    // low byte dropped, the symbol replaces the character
                    o_rd_class <= `CBC_CLS_SPECIAL; // RULE_09
                    o_rd_symbol <= evt; // RULE_08
                end else begin
                    o_rd_class <= `CBC_CLS_INVALID; // RULE_11
                    o_rd_line_side_select <= 1'b0;
                    o_rd_underline <= 1'b0;
                end
            end
        end
    end

    // write pointer wraps; oldest position is overwritten like a scroll buffer
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_q <= {BUF_AW{1'b0}};
            count_q <= {(BUF_AW+1){1'b0}};
        end else if (clr) begin
            wptr_q <= {BUF_AW{1'b0}};
            count_q <= {(BUF_AW+1){1'b0}};
        end else if (drain) begin
            wptr_q <= wptr_q + 1'b1;
            // saturates at a full buffer so software can tell how much is valid
            if (count_q != DEPTH_WORDS[BUF_AW:0]) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_hit;
            if (wb_hit && !i_wb_we) begin
                case (i_wb_adr)
                    `CBC_REG_CTRL: o_wb_dat <= 32'h0000_0000;
                    `CBC_REG_WPTR: o_wb_dat <= {{(32-BUF_AW){1'b0}}, wptr_q};
                    `CBC_REG_COUNT: o_wb_dat <= {{(31-BUF_AW){1'b0}}, count_q};
                    `CBC_REG_STATUS: o_wb_dat <= {30'h0, f_full, f_empty};
                    default: o_wb_dat <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // cbc_codec

// ===== design/cbc_consts.vh
/*
 * constants for the character buffer event word codec: word fields, class
 * masks, event codes, register offsets.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef CBC_CONSTS_VH
`define CBC_CONSTS_VH

`define CBC_CLASS_DATA_MASK 16'h0100
`define CBC_CLASS_DATA_VAL 16'h0100
`define CBC_CLASS_SPEC_MASK 16'h8300
`define CBC_CLASS_SPEC_VAL 16'h0200
`define CBC_RSV_A_MASK 16'h0700
`define CBC_RSV_A_VAL 16'h0400
`define CBC_RSV_B_MASK 16'h0f00
`define CBC_RSV_B_VAL 16'h0800
`define CBC_SIDE_BIT 10
`define CBC_ALT_BIT 9
`define CBC_REV_BIT 11
`define CBC_HEX_BIT 12
`define CBC_LOW_BIT 13
`define CBC_BLINK_BIT 14
`define CBC_STRIKE_BIT 15
`define CBC_EVT_MSB 13
`define CBC_EVT_LSB 11
`define CBC_EVT_NONE 3'h0
`define CBC_CHAR_MSB 7
`define CBC_CHAR_LSB 0
`define CBC_CTRL_CLR_BIT 0
`define CBC_EVT_GOOD_CRC 3'h1
`define CBC_EVT_BAD_CRC 3'h2
`define CBC_EVT_ABORT 3'h3
`define CBC_EVT_FLAG 3'h4
`define CBC_EVT_SYNC 3'h5
`define CBC_EVT_BAD_CRC2 3'h6
`define CBC_EVT_GOOD_CRC2 3'h7
`define CBC_CLS_INVALID 2'h0
`define CBC_CLS_DATA 2'h1
`define CBC_CLS_SPECIAL 2'h2
`define CBC_BUF_BYTES 65536
`define CBC_WORD_BYTES 2
`define CBC_REG_CTRL 4'h0
`define CBC_REG_WPTR 4'h4
`define CBC_REG_COUNT 4'h8
`define CBC_REG_STATUS 4'hc
`define CBC_CTRL_RST 32'h0000_0001

`endif

// ===== design/cbc_fifo.v
/*
 * synchronous valid/ready fifo, parameter width and depth.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module cbc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire o_full,
    output wire o_empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign o_full = (cnt_q == DEPTH[AW:0]);
    assign o_empty = (cnt_q == {(AW+1){1'b0}});
    assign o_in_ready = !o_full;
    assign o_out_valid = !o_empty;
    assign o_out_data = mem[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // cbc_fifo

// ===== bench/cbc_codec_asserts.sv
/* assertions on the codec read port.
   assumes binding into cbc_codec with a single clock. */
`timescale 1ns/1ns
`include "cbc_consts.vh"
module cbc_codec_asserts (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_rd_req,
    input wire o_rd_valid,
    input wire [1:0] o_rd_class,
    input wire [7:0] o_rd_char,
    input wire o_rd_line_side_select,
    input wire o_rd_underline,
    input wire [2:0] o_rd_symbol
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // fields hold between results, so class relations are checked every cycle
    property p_lat; i_rd_req |-> ##2 o_rd_valid; endproperty
    a_lat: assert property (p_lat) else $error("read answer late");
    property p_why; o_rd_valid |-> $past(i_rd_req, 2); endproperty
    a_why: assert property (p_why) else $error("read answer unasked");
    property p_ul; o_rd_underline == o_rd_line_side_select; endproperty
    a_ul: assert property (p_ul) else $error("underline differs from side");
    property p_chr; o_rd_class != `CBC_CLS_DATA |-> o_rd_char == 8'h0; endproperty
    a_chr: assert property (p_chr) else $error("char shown on non data");
    property p_sym; o_rd_class != `CBC_CLS_SPECIAL |-> o_rd_symbol == 3'h0; endproperty
    a_sym: assert property (p_sym) else $error("symbol on non special");
    property p_snz; o_rd_class == `CBC_CLS_SPECIAL |-> o_rd_symbol != 3'h0; endproperty
    a_snz: assert property (p_snz) else $error("special without symbol");
    property p_inv; o_rd_class == `CBC_CLS_INVALID |-> !o_rd_line_side_select; endproperty
    a_inv: assert property (p_inv) else $error("invalid word rendered");
    property p_hold; !o_rd_valid |-> $stable(o_rd_class); endproperty
    a_hold: assert property (p_hold) else $error("class moved between results");
endmodule // cbc_codec_asserts
bind cbc_codec cbc_codec_asserts chk_u (.*);

// ===== bench/cbc_writer_model.sv
/* receive processor model: offers event words, holding each until taken.
   assumes the codec takes a word at an edge where valid and ready are high. */
`timescale 1ns/1ns
module cbc_writer_model (
    input wire i_clk,
    input wire i_ready,
    output reg o_valid = 1'b0,
    output reg [15:0] o_word = 16'h0
);
    task push(input [15:0] v, input more);
        begin
            o_valid <= 1'b1;
            o_word <= v;
            @(posedge i_clk);
            while (!i_ready) @(posedge i_clk);
            // released bus shows the inverse, so a stale word cannot pass
            if (!more) begin
                o_valid <= 1'b0;
                o_word <= ~v;
            end
        end
    endtask
endmodule // cbc_writer_model

// ===== bench/tb_char_buffer_event_word_codec.sv
/* bench: corner, event-code and seeded random words through the writer model,
   decoded reads and wishbone registers; assumes the codec and writer model. */
`timescale 1ns/1ns
`include "cbc_consts.vh"
module tb_char_buffer_event_word_codec;
    localparam N = 40;
    localparam [63:0] COR = 64'h0541_8200_0800_ffff;
    reg i_clk = 1'b0, i_rst_n = 1'b0, i_rd_req = 1'b0;
    reg i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    reg [14:0] i_rd_addr = 15'h0;
    reg [3:0] i_wb_adr = 4'h0, i_wb_sel = 4'hf;
    reg [31:0] i_wb_dat = 32'h0;
    reg [15:0] w, mem [0:N-1];
    wire i_ev_valid, o_ev_ready, o_rd_valid, o_wb_ack;
    wire [15:0] i_ev_word;
    wire [20:0] got;
    wire [31:0] o_wb_dat;
    integer seed = 71, err_total = 0, tests_run = 0, cyc_n = 0, i;
    initial forever #5 i_clk = ~i_clk;
    cbc_writer_model wr_u (.i_clk, .i_ready(o_ev_ready),
        .o_valid(i_ev_valid), .o_word(i_ev_word));
    cbc_codec dut_u (.*, .o_rd_class(got[20:19]), .o_rd_char(got[18:11]),
        .o_rd_line_side_select(got[10]), .o_rd_underline(got[9]), .o_rd_strike(got[8]),
        .o_rd_blink(got[7]), .o_rd_low(got[6]), .o_rd_hex(got[5]), .o_rd_reverse(got[4]),
        .o_rd_alt_set(got[3]), .o_rd_symbol(got[2:0]));
    function [20:0] dec(input [15:0] v);
        begin
            dec = {`CBC_CLS_INVALID, 19'h0};
            if (v[8])
                dec = {`CBC_CLS_DATA, v[7:0], v[10], v[10], v[15:11], v[9], 3'h0};
            else if (!v[15] && v[9] && v[13:11] != 3'h0)
                dec = {`CBC_CLS_SPECIAL, 8'h0, v[10], v[10], 6'h0, v[13:11]};
        end
    endfunction
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("BAD %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wb(input we, input [3:0] a, input [31:0] d, input [31:0] e);
        begin
            i_wb_cyc <= 1'b1;
            i_wb_stb <= 1'b1;
            i_wb_we <= we;
            i_wb_adr <= a;
            i_wb_dat <= d;
            @(posedge i_clk);
            while (!o_wb_ack) @(posedge i_clk);
            if (!we)
                chk("register", e, o_wb_dat);
            i_wb_cyc <= 1'b0;
            i_wb_stb <= 1'b0;
            @(posedge i_clk);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge i_clk) begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 5000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    initial begin
        for (i = 0; i < N; i = i + 1) begin
            w = $random(seed);
            if (i < 4)
                w = COR[63 - 16 * i -: 16];
            else if (i < 11)
                w = 16'h0600 | {i[2:0] + 3'h5, 11'h0};
            else if (w[9:8] == 2'h2)
                w[14] = 1'b0;
            mem[i] = w;
        end
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk("ready", 32'h1, {31'h0, o_ev_ready});
        for (i = 0; i < N; i = i + 1)
            wr_u.push(mem[i], i < N - 1);
        repeat (4) @(posedge i_clk);
        $display("writes done");
        wb(1'b0, `CBC_REG_WPTR, 32'h0, N);
        wb(1'b0, `CBC_REG_COUNT, 32'h0, N);
        wb(1'b0, `CBC_REG_STATUS, 32'h0, 32'h1);
        wb(1'b0, 4'h2, 32'h0, 32'h0);
        for (i = 0; i < N; i = i + 1) begin
            i_rd_req <= 1'b1;
            i_rd_addr <= i[14:0];
            @(posedge i_clk);
            i_rd_req <= 1'b0;
            while (!o_rd_valid) @(posedge i_clk);
            chk("decode", {11'h0, dec(mem[i])}, {11'h0, got});
        end
        $display("decode done");
        wb(1'b1, `CBC_REG_CTRL, `CBC_CTRL_RST, 32'h0);
        wb(1'b0, `CBC_REG_WPTR, 32'h0, 32'h0);
        wb(1'b0, `CBC_REG_COUNT, 32'h0, 32'h0);
        $display("clear done");
        stop_test;
    end
endmodule // tb_char_buffer_event_word_codec
